// ==== src/secr_dev.sv ====
// Summary of operation
// - no address acknowledge while programming runs
// - acknowledge again once programming has finished
// - inputs ignored during program cycle, polling allowed
// - parameter page write uses type 1011, select 00
// - low word address byte picks page byte
// - frozen page: data not acknowledged, unchanged
// - freeze command: select 10, data bit one
// - repeated freeze command data gets no acknowledge
// - protect write: select 11, low two bits
// - protect field codes cover none/quarter/half/all
// - several protect data bytes cancel the write
// - protect write ignores hardware write-protect pin
// - protect read: upper six zero, repeats value
// - read address byte types and strap match
// - reads ignore write-protect pin and field
// - current read sends counter byte, then increments
// - array reads wrap from last to first
// - one counter shared by all spaces
// - random read: dummy write, repeated start, read
// - each master acknowledge advances to next byte
// - master ends read with nack and stop
// - master should prefer random reads for array
// - only stop right after data acknowledge programs
module secr_dev #(
  parameter int unsigned   PROG_CYCLES  = secr_pkg::PROG_CYCLES_DFLT,
  // arbitrary serial block content
  parameter logic [127:0]  SERIAL_VALUE = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978
) (
  input  wire logic SYS_CLK_I,
  input  wire logic NRST_I,
  secr_if.dev       LINK,
  input  wire logic CHIP_SELECT_HI_I,
  input  wire logic CHIP_SELECT_LO_I,
  input  wire logic WRITE_PROTECT_I,
  output logic      BUSY_O,
  output logic      PAGE_FROZEN_O
);
  logic [2:0]            scl_q;
  logic [2:0]            sda_q;
  logic [2:0]            pin_q1;
  logic [2:0]            pin_q2;
  logic                  scl_rise, scl_fall, start_det, stop_det, active;
  logic                  byte_end, ack_end, dev_match, wr_allow, wr_buf, launch;
  secr_pkg::secr_dstate_t state_r, nxt_r;
  logic [3:0]            bit_cnt_r;
  logic [7:0]            shift_r, tx_r, pdata_r, rd_byte;
  logic                  in_ack_r, sda_drv_r, special_r, a16_r, mnack_r;
  logic                  launch_ok_r, busy_r, frozen_r;
  logic [1:0]            space_r, prot_r, ndata_r;
  logic [7:0]            wa_hi_r;
  logic [16:0]           addr_r, addr_inc;
  logic [31:0]           busy_cnt_r;
  logic [8:0]            copy_idx_r;
  logic [255:0]          pmask_r;
  logic [7:0]            mem_r   [0:secr_pkg::ARRAY_BYTES-1];
  logic [7:0]            param_r [0:secr_pkg::PAGE_BYTES-1];
  logic [7:0]            pbuf_r  [0:secr_pkg::PAGE_BYTES-1];

  // two flops on every link and pin input before any logic looks at it; NRST_I is used directly
  always_ff @(posedge SYS_CLK_I)
  begin
    scl_q  <= {scl_q[1:0], LINK.scl};
    sda_q  <= {sda_q[1:0], LINK.sda};
    pin_q1 <= {CHIP_SELECT_HI_I, CHIP_SELECT_LO_I, WRITE_PROTECT_I};
    pin_q2 <= pin_q1;
  end

  // edge and bus-condition detection on the synchronised copies
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign active    = (state_r != secr_pkg::D_IDLE) && (state_r != secr_pkg::D_WAIT);
  assign byte_end  = scl_fall & active & ~in_ack_r & (bit_cnt_r == secr_pkg::BIT_CNT_BYTE);
  assign ack_end   = scl_fall & active & in_ack_r;
  assign dev_match = (shift_r[7:5] == secr_pkg::TYPE_HI3) && (shift_r[3:2] == pin_q2[2:1]);

  // may this data byte be taken
  always_comb
  begin
    wr_allow = 1'b0;
    if (!special_r)
    begin
      unique case (prot_r)
        secr_pkg::PROT_NONE:    wr_allow = 1'b1;
        secr_pkg::PROT_QUARTER: wr_allow = addr_r < secr_pkg::PROT_QTR_START;
        secr_pkg::PROT_HALF:    wr_allow = addr_r < secr_pkg::PROT_HALF_START;
        secr_pkg::PROT_ALL:     wr_allow = 1'b0;
      endcase
      wr_allow = wr_allow & ~pin_q2[0];
    end
    else
    begin
      unique case (space_r)
        secr_pkg::SPACE_PARAM_PAGE: wr_allow = ~frozen_r;
        secr_pkg::SPACE_SERIAL:     wr_allow = 1'b0;
        secr_pkg::SPACE_FREEZE:     wr_allow = ~frozen_r;
        secr_pkg::SPACE_PROTECT:    wr_allow = 1'b1;
      endcase
    end
  end
  assign wr_buf = byte_end && (state_r == secr_pkg::D_WDATA) && wr_allow;

  // read source and counter advance per space; reads never check protection
  always_comb
  begin
    rd_byte  = mem_r[addr_r];
    addr_inc = addr_r + 17'h0_0001;
    if (special_r)
    begin
      unique case (space_r)
        secr_pkg::SPACE_PARAM_PAGE:
        begin
          rd_byte  = param_r[addr_r[7:0]];
          addr_inc = {9'h000, addr_r[7:0] + 8'h01};
        end
        secr_pkg::SPACE_SERIAL:
        begin
          rd_byte  = SERIAL_VALUE[8'(127 - 8 * addr_r[3:0]) -: 8];
          addr_inc = {13'h0000, addr_r[3:0] + 4'h1};
        end
        secr_pkg::SPACE_FREEZE:
        begin
          rd_byte  = {7'h00, frozen_r};
          addr_inc = addr_r;
        end
        secr_pkg::SPACE_PROTECT:
        begin
          rd_byte  = {6'h00, prot_r};
          addr_inc = addr_r;
        end
      endcase
    end
  end

  // a write is launched only by a stop right after an acknowledged data byte
  always_comb
  begin
    launch = stop_det & ~busy_r & launch_ok_r;
    if (special_r && space_r == secr_pkg::SPACE_PROTECT)
      launch = launch & (ndata_r == 2'h1);
    if (special_r && space_r == secr_pkg::SPACE_FREEZE)
      launch = launch & pdata_r[secr_pkg::FREEZE_DATA_BIT];
  end

  // protocol engine: bit counting, acknowledge slots, shared counter
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I)
    begin
      state_r     <= secr_pkg::D_IDLE;
      nxt_r       <= secr_pkg::D_IDLE;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      pdata_r     <= 8'h00;
      in_ack_r    <= 1'b0;
      sda_drv_r   <= 1'b0;
      special_r   <= 1'b0;
      a16_r       <= 1'b0;
      mnack_r     <= 1'b0;
      launch_ok_r <= 1'b0;
      busy_r      <= 1'b0;
      busy_cnt_r  <= 32'h0000_0000;
      frozen_r    <= 1'b0;
      space_r     <= secr_pkg::SPACE_PARAM_PAGE;
      prot_r      <= secr_pkg::PROT_RESET;
      ndata_r     <= 2'h0;
      wa_hi_r     <= 8'h00;
      addr_r      <= 17'h0_0000;
    end
    else if (busy_r)
    begin
      // inputs ignored, so polling address bytes see no acknowledge
      state_r    <= secr_pkg::D_IDLE;
      sda_drv_r  <= 1'b0;
      busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
      if (busy_cnt_r == 32'(PROG_CYCLES - 1))
        busy_r <= 1'b0;
    end
    else if (start_det)
    begin
      // a start, repeated or not, drops any half-sent write
      state_r     <= secr_pkg::D_DEV;
      bit_cnt_r   <= 4'h0;
      in_ack_r    <= 1'b0;
      sda_drv_r   <= 1'b0;
      launch_ok_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r     <= secr_pkg::D_IDLE;
      sda_drv_r   <= 1'b0;
      launch_ok_r <= 1'b0;
      if (launch)
      begin
        busy_r     <= 1'b1;
        busy_cnt_r <= 32'h0000_0000;
        if (special_r && space_r == secr_pkg::SPACE_FREEZE)
          frozen_r <= 1'b1;
        if (special_r && space_r == secr_pkg::SPACE_PROTECT)
          prot_r <= pdata_r[1:0];
      end
    end
    else if (scl_rise && active)
    begin
      // the tenth clock (first rise after a data acknowledge) keeps the launch armed for its stop
      launch_ok_r <= launch_ok_r && (bit_cnt_r == 4'h0) && !in_ack_r;
      if (in_ack_r)
        mnack_r <= sda_q[1];
      else
      begin
        shift_r   <= {shift_r[6:0], sda_q[1]};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
    else if (byte_end)
    begin
      in_ack_r  <= 1'b1;
      sda_drv_r <= 1'b0;
      unique case (state_r)
        secr_pkg::D_DEV:
        begin
          sda_drv_r <= dev_match;
          special_r <= shift_r[secr_pkg::TYPE_SPECIAL_BIT];
          a16_r     <= shift_r[1];
          nxt_r     <= !dev_match ? secr_pkg::D_WAIT : (shift_r[0] ? secr_pkg::D_RDATA : secr_pkg::D_WHI);
        end
        secr_pkg::D_WHI:
        begin
          sda_drv_r <= 1'b1;
          wa_hi_r   <= shift_r;
          nxt_r     <= secr_pkg::D_WLO;
        end
        secr_pkg::D_WLO:
        begin
          sda_drv_r <= 1'b1;
          ndata_r   <= 2'h0;
          nxt_r     <= secr_pkg::D_WDATA;
          space_r   <= wa_hi_r[secr_pkg::SPACE_SEL_LSB +: 2];
          if (!special_r)
            addr_r <= {a16_r, wa_hi_r, shift_r};
          else if (wa_hi_r[secr_pkg::SPACE_SEL_LSB +: 2] == secr_pkg::SPACE_SERIAL)
            addr_r <= {13'h0000, shift_r[3:0]};
          else
            addr_r <= {9'h000, shift_r};
        end
        secr_pkg::D_WDATA:
        begin
          sda_drv_r <= wr_allow;
          pdata_r   <= shift_r;
          nxt_r     <= secr_pkg::D_WDATA;
          if (ndata_r != 2'h3)
            ndata_r <= ndata_r + 2'h1;
          if (wr_allow)
            addr_r <= {addr_r[16:8], addr_r[7:0] + 8'h01}; // page rollover on writes
        end
        secr_pkg::D_RDATA: nxt_r <= secr_pkg::D_RDATA; // master owns this slot
        default:           nxt_r <= secr_pkg::D_WAIT;
      endcase
    end
    else if (ack_end)
    begin
      in_ack_r    <= 1'b0;
      bit_cnt_r   <= 4'h0;
      sda_drv_r   <= 1'b0;
      launch_ok_r <= (state_r == secr_pkg::D_WDATA) && sda_drv_r;
      if ((state_r == secr_pkg::D_RDATA && mnack_r) || nxt_r == secr_pkg::D_WAIT)
        state_r <= secr_pkg::D_WAIT;
      else
      begin
        state_r <= nxt_r;
        if (nxt_r == secr_pkg::D_RDATA)
        begin
          // send byte at counter, then advance it
          tx_r      <= rd_byte;
          sda_drv_r <= ~rd_byte[7];
          addr_r    <= addr_inc;
        end
      end
    end
    else if (scl_fall && state_r == secr_pkg::D_RDATA && !in_ack_r)
    begin
      sda_drv_r <= ~tx_r[6];
      tx_r      <= {tx_r[6:0], 1'b0};
    end
  end

  // page buffer and its byte mask; the mask is cleared by every start outside a program cycle
  always_ff @(posedge SYS_CLK_I)
  begin
    if (wr_buf)
      pbuf_r[addr_r[7:0]] <= shift_r;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I || (start_det && !busy_r))
      pmask_r <= '0;
    else if (wr_buf)
      pmask_r[addr_r[7:0]] <= 1'b1;
  end

  // programming walks the mask once; needs PROG_CYCLES above the page size
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I || !busy_r)
      copy_idx_r <= 9'h000;
    else if (!copy_idx_r[8])
      copy_idx_r <= copy_idx_r + 9'h001;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (busy_r && !copy_idx_r[8] && pmask_r[copy_idx_r[7:0]])
    begin
      if (!special_r)
        mem_r[{addr_r[16:8], copy_idx_r[7:0]}] <= pbuf_r[copy_idx_r[7:0]];
      else if (space_r == secr_pkg::SPACE_PARAM_PAGE)
        param_r[copy_idx_r[7:0]] <= pbuf_r[copy_idx_r[7:0]];
    end
  end

  assign LINK.dev_sda_o  = 1'b0;
  assign LINK.dev_sda_oe = sda_drv_r;
  assign BUSY_O          = busy_r;
  assign PAGE_FROZEN_O   = frozen_r;
endmodule

// ==== src/secr_host.sv ====
module secr_host (
  input  wire logic        SYS_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  secr_if.host             LINK
);
  logic [1:0]             sda_q;
  logic [1:0]             div_r;
  logic                   tick;
  secr_pkg::secr_hstate_t state_r;
  logic [1:0]             phase_r;
  logic [3:0]             bit_r;
  logic                   busy_r, do_stop_r, do_wr_r, do_rd_r, nack_r, dev_ack_r;
  logic                   scl_r, sda_low_r, ack_r, cmd_go;
  logic [7:0]             tx_r, tx_sh_r, rx_r;
  logic [31:0]            dat_r;

  // data line from the far end is asynchronous
  always_ff @(posedge SYS_CLK_I)
  begin
    sda_q <= {sda_q[0], LINK.sda};
  end

  // quarter-bit enable; four quarters form one link clock period
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I)
      div_r <= 2'h0;
    else
      div_r <= (div_r == 2'(secr_pkg::QTR_CYCLES - 1)) ? 2'h0 : div_r + 2'h1;
  end
  assign tick = (div_r == 2'h0);

  // classic bus slave: answer one cycle after the strobe, drop it next cycle
  assign cmd_go = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_r & WB_SEL_I[0] & ~busy_r
                  & (WB_ADR_I == secr_pkg::HREG_CTRL);
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      tx_r  <= 8'h00;
    end
    else
    begin
      ack_r <= WB_CYC_I & WB_STB_I & ~ack_r;
      dat_r <= 32'h0000_0000;
      if (WB_CYC_I && WB_STB_I && !ack_r)
      begin
        if (WB_WE_I && WB_SEL_I[0] && WB_ADR_I == secr_pkg::HREG_TX)
          tx_r <= WB_DAT_I[7:0];
        if (!WB_WE_I)
        begin
          unique case (WB_ADR_I)
            secr_pkg::HREG_CTRL: dat_r <= {30'h0000_0000, dev_ack_r, busy_r};
            secr_pkg::HREG_TX:   dat_r <= {24'h00_0000, tx_r};
            secr_pkg::HREG_RX:   dat_r <= {24'h00_0000, rx_r};
            default:             dat_r <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // link sequencer: start, one byte out or in, stop, in that order
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I)
    begin
      state_r   <= secr_pkg::H_IDLE;
      phase_r   <= 2'h0;
      bit_r     <= 4'h0;
      busy_r    <= 1'b0;
      do_stop_r <= 1'b0;
      do_wr_r   <= 1'b0;
      do_rd_r   <= 1'b0;
      nack_r    <= 1'b0;
      dev_ack_r <= 1'b0;
      scl_r     <= 1'b1;
      sda_low_r <= 1'b0;
      tx_sh_r   <= 8'h00;
      rx_r      <= 8'h00;
    end
    else if (cmd_go)
    begin
      busy_r    <= 1'b1;
      do_stop_r <= WB_DAT_I[secr_pkg::CTRL_STOP_BIT];
      do_wr_r   <= WB_DAT_I[secr_pkg::CTRL_WRITE_BIT];
      do_rd_r   <= WB_DAT_I[secr_pkg::CTRL_READ_BIT] & ~WB_DAT_I[secr_pkg::CTRL_WRITE_BIT];
      nack_r    <= WB_DAT_I[secr_pkg::CTRL_NACK_BIT];
      tx_sh_r   <= tx_r;
      phase_r   <= 2'h0;
      bit_r     <= 4'h0;
      if (WB_DAT_I[secr_pkg::CTRL_START_BIT])
        state_r <= secr_pkg::H_START;
      else if (WB_DAT_I[secr_pkg::CTRL_WRITE_BIT] || WB_DAT_I[secr_pkg::CTRL_READ_BIT])
        state_r <= secr_pkg::H_BIT;
      else if (WB_DAT_I[secr_pkg::CTRL_STOP_BIT])
        state_r <= secr_pkg::H_STOP;
      else
        busy_r <= 1'b0;
    end
    else if (tick && state_r != secr_pkg::H_IDLE)
    begin
      phase_r <= phase_r + 2'h1;
      unique case (state_r)
        secr_pkg::H_START:
        begin
          // release data, raise clock, pull data low, lower clock
          unique case (phase_r)
            2'h0: sda_low_r <= 1'b0;
            2'h1: scl_r     <= 1'b1;
            2'h2: sda_low_r <= 1'b1;
            2'h3:
            begin
              scl_r <= 1'b0;
              if (do_wr_r || do_rd_r)
                state_r <= secr_pkg::H_BIT;
              else if (do_stop_r)
                state_r <= secr_pkg::H_STOP;
              else
              begin
                state_r <= secr_pkg::H_IDLE;
                busy_r  <= 1'b0;
              end
            end
          endcase
        end
        secr_pkg::H_BIT:
        begin
          unique case (phase_r)
            2'h0:
            begin
              if (bit_r != 4'h8)
                sda_low_r <= do_wr_r & ~tx_sh_r[7];
              else
                sda_low_r <= do_rd_r & ~nack_r;
            end
            2'h1: scl_r <= 1'b1;
            2'h2:
            begin
              if (bit_r != 4'h8)
                rx_r <= {rx_r[6:0], sda_q[1]};
              else if (do_wr_r)
                dev_ack_r <= ~sda_q[1];
            end
            2'h3:
            begin
              scl_r   <= 1'b0;
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              bit_r   <= bit_r + 4'h1;
              if (bit_r == 4'h8)
              begin
                if (do_stop_r)
                  state_r <= secr_pkg::H_STOP;
                else
                begin
                  state_r   <= secr_pkg::H_IDLE;
                  busy_r    <= 1'b0;
                  sda_low_r <= 1'b0;
                end
              end
            end
          endcase
        end
        secr_pkg::H_STOP:
        begin
          // pull data low, raise clock, release data while clock is high
          unique case (phase_r)
            2'h0: sda_low_r <= 1'b1;
            2'h1: scl_r     <= 1'b1;
            2'h2: sda_low_r <= 1'b0;
            2'h3:
            begin
              state_r <= secr_pkg::H_IDLE;
              busy_r  <= 1'b0;
            end
          endcase
        end
        default: state_r <= secr_pkg::H_IDLE;
      endcase
    end
  end

  assign LINK.scl_o       = scl_r;
  assign LINK.host_sda_o  = 1'b0;
  assign LINK.host_sda_oe = sda_low_r;
  assign WB_DAT_O         = dat_r;
  assign WB_ACK_O         = ack_r;
endmodule

// ==== src/secr_if.sv ====
interface secr_if;
  logic scl_o;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain data line: any enabled low driver pulls it down
  assign scl = scl_o;
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output scl_o, output host_sda_o, output host_sda_oe);
endinterface

// ==== src/secr_pkg.sv ====
package secr_pkg;
  // system clock and derived link timing
  localparam int unsigned CLK_MHZ           = 100;
  localparam int unsigned QTR_CYCLES        = 4;
  // program cycle length in microseconds, cycles derived from the clock rate
  localparam int unsigned PROG_TIME_US      = 1000;
  localparam int unsigned PROG_CYCLES_DFLT  = PROG_TIME_US * CLK_MHZ;

  // address byte layout
  localparam logic [2:0]  TYPE_HI3          = 3'h5;
  localparam int unsigned TYPE_SPECIAL_BIT  = 4;
  localparam logic [3:0]  BIT_CNT_BYTE      = 4'h8;

  // memory geometry
  localparam int unsigned ARRAY_BYTES       = 131072;
  localparam int unsigned PAGE_BYTES        = 256;
  localparam int unsigned SERIAL_BYTES      = 16;
  localparam logic [16:0] PROT_QTR_START    = 17'h1_8000;
  localparam logic [16:0] PROT_HALF_START   = 17'h1_0000;

  // special space select (word address bits ten and nine)
  localparam logic [1:0]  SPACE_PARAM_PAGE  = 2'h0;
  localparam logic [1:0]  SPACE_SERIAL      = 2'h1;
  localparam logic [1:0]  SPACE_FREEZE      = 2'h2;
  localparam logic [1:0]  SPACE_PROTECT     = 2'h3;
  localparam int unsigned SPACE_SEL_LSB     = 1;

  // protection field codes and reset values
  localparam logic [1:0]  PROT_NONE         = 2'h0;
  localparam logic [1:0]  PROT_QUARTER      = 2'h1;
  localparam logic [1:0]  PROT_HALF         = 2'h2;
  localparam logic [1:0]  PROT_ALL          = 2'h3;
  localparam logic [1:0]  PROT_RESET        = 2'h0;
  localparam int unsigned FREEZE_DATA_BIT   = 1;

  // host register map (byte addresses)
  localparam logic [7:0]  HREG_CTRL         = 8'h00;
  localparam logic [7:0]  HREG_TX           = 8'h04;
  localparam logic [7:0]  HREG_RX           = 8'h08;
  localparam int unsigned CTRL_START_BIT    = 0;
  localparam int unsigned CTRL_STOP_BIT     = 1;
  localparam int unsigned CTRL_WRITE_BIT    = 2;
  localparam int unsigned CTRL_READ_BIT     = 3;
  localparam int unsigned CTRL_NACK_BIT     = 4;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_ACK_BIT      = 1;

  typedef enum logic [2:0] {
    D_IDLE, D_DEV, D_WHI, D_WLO, D_WDATA, D_RDATA, D_WAIT
  } secr_dstate_t;

  typedef enum logic [1:0] {
    H_IDLE, H_START, H_BIT, H_STOP
  } secr_hstate_t;
endpackage

// ==== tb/secr_assertions.sv ====
module secr_assertions #(
  parameter int unsigned PROG_CYCLES = 400
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic BUSY_O
);
  logic [31:0] cnt_r;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  // busy length counter, cleared whenever the program cycle is not running
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!NRST_I || !BUSY_O)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 32'h0000_0001;
  end

  a_busy_no_ack: assert property (BUSY_O |-> !dev_sda_oe)
    else $error("device drives data while busy");
  a_busy_hold: assert property ($rose(BUSY_O) |=> BUSY_O [*8])
    else $error("program cycle cut short");
  a_prog_max: assert property (cnt_r <= PROG_CYCLES + 1)
    else $error("program cycle too long");
  a_prog_len: assert property ($fell(BUSY_O) |-> cnt_r inside {[PROG_CYCLES - 1:PROG_CYCLES + 1]})
    else $error("program cycle length wrong");
  a_launch_on_stop: assert property ($rose(BUSY_O) |-> scl && sda)
    else $error("program cycle started outside a stop");
  a_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed with clock high");
  a_oe_after_fall: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device drove data too early after clock fall");
  a_idle_release: assert property (scl && $rose(sda) |=> !dev_sda_oe [*8])
    else $error("device drives data after stop");

  // main scenarios reached
  c_busy: cover property ($rose(BUSY_O));
  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_prog_end: cover property ($fell(BUSY_O));
endmodule

// ==== tb/serial_eeprom_cmd_readout_tb.sv ====
module serial_eeprom_cmd_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] C_S = 5'h01;
  localparam logic [4:0] C_P = 5'h02;
  localparam logic [4:0] C_W = 5'h04;
  localparam logic [4:0] C_R = 5'h08;
  localparam logic [4:0] C_N = 5'h10;
  logic        clk, nrst, cyc, stb, we, mon, ack, cs_hi, cs_lo, wp, busy, frozen;
  logic [7:0]  adr, st, dev_a, spc_a, d0, d1;
  logic [31:0] dat, dat_o;
  logic [16:0] addr;
  logic [7:0]  q[$];
  int          n_errors, cmp_count;

  secr_if link();
  secr_dev #(.PROG_CYCLES(1000)) secr_dev_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .LINK(link.dev),
    .CHIP_SELECT_HI_I(cs_hi), .CHIP_SELECT_LO_I(cs_lo), .WRITE_PROTECT_I(wp), .BUSY_O(busy), .PAGE_FROZEN_O(frozen));
  secr_host secr_host_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LINK(link.host));
  secr_assertions #(.PROG_CYCLES(1000)) secr_assertions_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe(link.dev_sda_oe), .BUSY_O(busy));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one classic cycle; a checked read notes its expectation first
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input bit c, input logic [7:0] e,
                    output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    mon <= c;
    if (c)
      q.push_back(e);
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    mon <= 1'b0;
  endtask

  // one link command; e < 0 skips the acknowledge check
  task automatic op(input logic [4:0] c, input logic [7:0] tx, input int e);
    if (c[2])
      wb(1'b1, 8'h04, tx, 1'b0, 8'h00, st);
    wb(1'b1, 8'h00, {3'h0, c}, 1'b0, 8'h00, st);
    do wb(1'b0, 8'h00, 8'h00, 1'b0, 8'h00, st); while (st[0] !== 1'b0);
    if (e >= 0)
      wb(1'b0, 8'h00, 8'h00, 1'b1, {6'h00, e[0], 1'b0}, st);
  endtask

  task automatic tx3(input logic [7:0] dv, input logic [7:0] hi, input logic [7:0] lo);
    op(C_S | C_W, dv, 1);
    op(C_W, hi, 1);
    op(C_W, lo, 1);
  endtask

  task automatic rx(input logic [7:0] e);
    wb(1'b0, 8'h08, 8'h00, 1'b1, e, st);
  endtask

  // random read of two bytes: dummy write, repeated start, ack then nack
  task automatic rrd(input logic [7:0] dv, input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] e0,
                     input logic [7:0] e1);
    tx3(dv, hi, lo);
    op(C_S | C_W, dv | 8'h01, 1);
    op(C_R, 8'h00, -1);
    rx(e0);
    op(C_R | C_N | C_P, 8'h00, -1);
    rx(e1);
  endtask

  task automatic curr(input logic [7:0] e);
    op(C_S | C_W, dev_a | 8'h01, 1);
    op(C_R | C_N | C_P, 8'h00, -1);
    rx(e);
  endtask

  // polling must first be refused, then answered within a bounded count
  task automatic poll();
    int k;
    k = 0;
    op(C_S | C_W | C_P, dev_a, 0);
    do
    begin
      op(C_S | C_W | C_P, dev_a, -1);
      k++;
    end
    while (st[1] !== 1'b1 && k < 30);
    wb(1'b0, 8'h00, 8'h00, 1'b1, 8'h02, st);
  endtask

  // compare each checked read with the oldest noted expectation
  always @(posedge clk)
  begin
    if (ack === 1'b1 && mon === 1'b1)
      check("read data", dat_o[7:0], q.pop_front());
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog sized well beyond the expected run
  initial
  begin
    #(900_000);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    {nrst, cyc, stb, we, mon, wp} = 6'h00;
    adr = 8'h00;
    dat = 32'h0000_0000;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(88687));
    cs_hi = 1'($urandom);
    cs_lo = 1'($urandom);
    dev_a = {4'hA, cs_hi, cs_lo, 2'h0};
    spc_a = {4'hB, cs_hi, cs_lo, 2'h0};
    addr = 17'($urandom) & 17'h0_FFFE;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    tx3(dev_a, addr[15:8], addr[7:0]);
    op(C_W, d0, 1);
    op(C_W | C_P, d1, 1);
    poll();
    rrd(dev_a, addr[15:8], addr[7:0], d0, d1);
    tx3(dev_a, addr[15:8], addr[7:0]);
    op(C_P, 8'h00, -1);
    curr(d0);
    curr(d1);
    $display("test array write and reads done");
    wp <= 1'b1;
    tx3(spc_a, 8'h06, 8'h00);
    op(C_W | C_P, {6'($urandom), 2'h3}, 1);
    poll();
    wp <= 1'b0;
    tx3(spc_a, 8'h06, 8'h00);
    op(C_W, 8'h00, 1);
    op(C_W | C_P, 8'h00, -1);
    rrd(spc_a, 8'h06, 8'h00, 8'h03, 8'h03);
    tx3(dev_a, addr[15:8], addr[7:0]);
    op(C_W | C_P, ~d0, 0);
    rrd(dev_a, addr[15:8], addr[7:0], d0, d1);
    $display("test protection field done");
    tx3(spc_a, 8'h00, addr[7:0]);
    op(C_W, d1, 1);
    op(C_W | C_P, d0, 1);
    poll();
    tx3(spc_a, 8'h04, 8'h00);
    op(C_W | C_P, 8'h02, 1);
    poll();
    check("frozen flag", {7'h00, frozen}, 8'h01);
    tx3(spc_a, 8'h00, addr[7:0]);
    op(C_W | C_P, d0, 0);
    tx3(spc_a, 8'h04, 8'h00);
    op(C_W | C_P, 8'h02, 0);
    rrd(spc_a, 8'h00, addr[7:0], d1, d0);
    $display("test parameter page done");
    report_and_stop();
  end
endmodule
